// ---- rtl/sgss_selector.sv ----
// gain set selection, torque-mode limits and alarm of the servo gain switch
// ==========================================================================
// Notes on behaviour
// - low field 0: first gain set always, second never.
// - low field 1: second set while gain select terminal active, else first.
// - terminal mode without assigned gain select input stays on first set.
// - low field 2: switch on position deviation versus threshold plus 100.
// - low field 3: switch on speed command versus threshold plus 10 rpm.
// - low field 4: switch on motor speed versus threshold plus 10 rpm.
// - high field 1 with low field 0 keeps speed integral on unless integral time is 3000.0.
// - torque mode: at speed limit in torque direction, hand over to speed control.
// - speed limit only in torque direction; backdriven motor gets torque only.
// - backdriven motor in torque mode raises the regeneration alarm.
// - torque mode disables gain switching, filters, observers and compensations.
// - integral time setting 3000.0 turns speed integration off.
// - speed mode ignores position loop gain and speed feedforward gain.
// - position and speed gains ramp linearly to their targets over the change time; feedforward gain does not ramp.
// - second position gain is first position gain times its coefficient.
// - second speed gain is first speed gain times its coefficient.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "sgss_cfg.svh"

module sgss_selector #(
    parameter int TICK_CYC = `SGSS_TICK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire sgss_pkg::sgss_bus_s bus,
    output logic [15:0] rdata,
    input wire logic gain_sel,
    input wire sgss_pkg::sgss_loop_s loop_in,
    output logic [15:0] pos_gain_out,
    output logic [15:0] spd_gain_out,
    output logic [15:0] ff_gain_out,
    output logic integral_en,
    output logic second_active,
    output logic speed_limit_active,
    output logic signed [15:0] speed_limit_cmd,
    output sgss_pkg::sgss_feat_s feat_en,
    output logic regeneration_alarm,
    output logic [7:0] alarm_code
);
    import sgss_pkg::*;

    sgss_state_s s_q;
    sgss_state_s s_d;

    logic [3:0] sel_low;
    logic [3:0] sel_high;
    logic [16:0] abs_pos;
    logic [16:0] abs_scmd;
    logic [16:0] abs_mspd;
    logic [16:0] sum_pos;
    logic [16:0] sum_spd;
    logic [16:0] metric;
    logic [16:0] limit_sum;
    logic level_mode;
    logic want_second;
    logic is_trq;
    logic same_dir;
    logic back_dir;
    logic [31:0] pos2_prod;
    logic [31:0] spd2_prod;
    logic [15:0] pos2;
    logic [15:0] spd2;
    logic [15:0] pos_target;
    logic [15:0] spd_target;
    logic [15:0] pos_ramp;
    logic [15:0] spd_ramp;
    logic pos_busy;
    logic spd_busy;
    logic [15:0] status_word;

    // ======================================================================
    // magnitude helpers; 17 bits hold the most negative value
    function automatic logic [16:0] mag(input logic signed [15:0] v);
        logic signed [16:0] w;
        w = 17'(v);
        mag = w[16] ? 17'(-w) : 17'(w);
    endfunction : mag

    function automatic logic [15:0] sat16(input logic [31:0] v);
        logic [31:0] sh;
        sh = v >> `SGSS_COEF_FRAC;
        sat16 = (sh[31:16] != 16'h0000) ? 16'hFFFF : sh[15:0];
    endfunction : sat16

    // ======================================================================
    // decode of the selector and loop quantities
    always_comb begin
        sel_low = s_q.mode_sel[`SGSS_SEL_LOW_LSB +: 4];
        sel_high = s_q.mode_sel[`SGSS_SEL_HIGH_LSB +: 4];
        abs_pos = mag(loop_in.pos_dev);
        abs_scmd = mag(loop_in.speed_cmd);
        abs_mspd = mag(loop_in.motor_speed);
        sum_pos = 17'(s_q.thresh) + `SGSS_LAG_POS;
        sum_spd = 17'(s_q.thresh) + `SGSS_LAG_SPEED;
        is_trq = (s_q.ctrl_mode == SGSS_MODE_TRQ);
        level_mode = 1'b1;
        metric = 17'h00000;
        want_second = 1'b0;
        case (sel_low)
            `SGSS_LOW_FIXED: begin
                want_second = 1'b0;
            end
            `SGSS_LOW_TERMINAL: begin
                // unassigned terminal pins the first set
                want_second = s_q.gsel_assigned && gain_sel;
            end
            `SGSS_LOW_POS_DEV: begin
                level_mode = 1'b0;
                metric = abs_pos;
            end
            `SGSS_LOW_SPD_CMD: begin
                level_mode = 1'b0;
                metric = abs_scmd;
            end
            `SGSS_LOW_MOTOR_SPD: begin
                level_mode = 1'b0;
                metric = abs_mspd;
            end
            default: begin
                want_second = 1'b0;
            end
        endcase
        limit_sum = (sel_low == `SGSS_LOW_POS_DEV) ? sum_pos : sum_spd;
        if (!level_mode) begin
            // at exactly the sum the present set is kept
            if (!s_q.second) begin
                want_second = (metric > limit_sum);
            end else begin
                want_second = !(metric < limit_sum);
            end
        end
    end

    // ======================================================================
    // direction relation of motor speed and torque command
    always_comb begin
        same_dir = (loop_in.motor_speed != 16'sh0000) && (loop_in.torque_cmd != 16'sh0000) &&
                   (loop_in.motor_speed[15] == loop_in.torque_cmd[15]);
        back_dir = (loop_in.motor_speed != 16'sh0000) && (loop_in.torque_cmd != 16'sh0000) && !same_dir;
    end

    // ======================================================================
    // second gain set and ramp targets
    always_comb begin
        pos2_prod = 32'(s_q.pos_gain) * 32'(s_q.pos_coef);
        spd2_prod = 32'(s_q.spd_gain) * 32'(s_q.spd_coef);
        pos2 = sat16(pos2_prod);
        spd2 = sat16(spd2_prod);
        pos_target = s_q.second ? pos2 : s_q.pos_gain;
        spd_target = s_q.second ? spd2 : s_q.spd_gain;
        if (s_q.ctrl_mode == SGSS_MODE_SPD) begin
            pos_target = 16'h0000;
        end
    end

    sgss_gain_ramp #(
        .TICK_CYC(TICK_CYC)
    ) u_pos_ramp (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .target(pos_target),
        .ramp_len(s_q.ramp_time),
        .value(pos_ramp),
        .busy(pos_busy)
    );

    sgss_gain_ramp #(
        .TICK_CYC(TICK_CYC)
    ) u_spd_ramp (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .target(spd_target),
        .ramp_len(s_q.ramp_time),
        .value(spd_ramp),
        .busy(spd_busy)
    );

    always_comb begin
        status_word = 16'h0000;
        status_word[`SGSS_ST_SECOND_BIT] = s_q.second;
        status_word[`SGSS_ST_LIMIT_BIT] = s_q.limit;
        status_word[`SGSS_ST_ALARM_BIT] = s_q.alarm;
        status_word[`SGSS_ST_INTEG_BIT] = s_q.integ;
        status_word[`SGSS_ST_RAMP_BIT] = pos_busy | spd_busy;
    end

    // ======================================================================
    // next state: register port, selection, torque-mode logic
    always_comb begin
        s_d = s_q;
        s_d.rdata = 16'h0000;
        if (bus.wr) begin
            case (bus.addr)
                `SGSS_OFF_MODE_SEL: s_d.mode_sel = bus.wdata;
                `SGSS_OFF_THRESH: s_d.thresh = bus.wdata;
                `SGSS_OFF_RAMP_TIME: s_d.ramp_time = bus.wdata;
                `SGSS_OFF_POS_GAIN: s_d.pos_gain = bus.wdata;
                `SGSS_OFF_SPD_GAIN: s_d.spd_gain = bus.wdata;
                `SGSS_OFF_POS_COEF: s_d.pos_coef = bus.wdata;
                `SGSS_OFF_SPD_COEF: s_d.spd_coef = bus.wdata;
                `SGSS_OFF_INT_TIME: s_d.int_time = bus.wdata;
                `SGSS_OFF_FF_GAIN: s_d.ff_gain = bus.wdata;
                `SGSS_OFF_CTRL: begin
                    // code 3 falls back to position control
                    case (bus.wdata[1:0])
                        2'h1: s_d.ctrl_mode = SGSS_MODE_SPD;
                        2'h2: s_d.ctrl_mode = SGSS_MODE_TRQ;
                        default: s_d.ctrl_mode = SGSS_MODE_POS;
                    endcase
                    s_d.gsel_assigned = bus.wdata[`SGSS_CTRL_GSEL_BIT];
                end
                `SGSS_OFF_SPD_LIMIT: s_d.spd_limit = bus.wdata;
                `SGSS_OFF_STATUS: begin
                    if (bus.wdata[`SGSS_ST_ALARM_BIT]) begin
                        s_d.alarm = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                `SGSS_OFF_MODE_SEL: s_d.rdata = s_q.mode_sel;
                `SGSS_OFF_THRESH: s_d.rdata = s_q.thresh;
                `SGSS_OFF_RAMP_TIME: s_d.rdata = s_q.ramp_time;
                `SGSS_OFF_POS_GAIN: s_d.rdata = s_q.pos_gain;
                `SGSS_OFF_SPD_GAIN: s_d.rdata = s_q.spd_gain;
                `SGSS_OFF_POS_COEF: s_d.rdata = s_q.pos_coef;
                `SGSS_OFF_SPD_COEF: s_d.rdata = s_q.spd_coef;
                `SGSS_OFF_INT_TIME: s_d.rdata = s_q.int_time;
                `SGSS_OFF_FF_GAIN: s_d.rdata = s_q.ff_gain;
                `SGSS_OFF_CTRL: s_d.rdata = {13'h0000, s_q.gsel_assigned, s_q.ctrl_mode};
                `SGSS_OFF_SPD_LIMIT: s_d.rdata = s_q.spd_limit;
                `SGSS_OFF_STATUS: s_d.rdata = status_word;
                `SGSS_OFF_POS_OUT: s_d.rdata = pos_ramp;
                `SGSS_OFF_SPD_OUT: s_d.rdata = spd_ramp;
                default: s_d.rdata = 16'h0000;
            endcase
        end

        // with high field 1 the condition steers the integral, not the set
        if (is_trq || sel_high == `SGSS_HIGH_INTEG) begin
            s_d.second = 1'b0;
        end else begin
            s_d.second = want_second;
        end
        if (s_q.int_time == `SGSS_INT_OFF) begin
            s_d.integ = 1'b0;
        end else if (sel_high == `SGSS_HIGH_INTEG && sel_low == `SGSS_LOW_FIXED) begin
            s_d.integ = 1'b1;
        end else if (sel_high == `SGSS_HIGH_INTEG && !is_trq) begin
            s_d.integ = !want_second;
        end else begin
            s_d.integ = 1'b1;
        end

        // limit acts only in the torque direction; backdriving is unlimited
        s_d.limit = is_trq && same_dir && (abs_mspd >= 17'(s_q.spd_limit));
        s_d.limit_cmd = loop_in.torque_cmd[15] ? 16'(-$signed({1'b0, s_q.spd_limit}))
                                               : $signed(s_q.spd_limit);
        // sticky: a new backdrive event beats a clear in the same cycle
        if (is_trq && back_dir) begin
            s_d.alarm = 1'b1;
        end

        s_d.feat = is_trq ? '0 : '1;
        s_d.ff_out = (s_q.ctrl_mode == SGSS_MODE_SPD) ? 16'h0000 : s_q.ff_gain;
    end

    // ======================================================================
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.mode_sel <= `SGSS_RST_MODE_SEL;
            s_q.thresh <= `SGSS_RST_THRESH;
            s_q.ramp_time <= `SGSS_RST_RAMP_TIME;
            s_q.pos_gain <= `SGSS_RST_POS_GAIN;
            s_q.spd_gain <= `SGSS_RST_SPD_GAIN;
            s_q.pos_coef <= `SGSS_RST_POS_COEF;
            s_q.spd_coef <= `SGSS_RST_SPD_COEF;
            s_q.int_time <= `SGSS_RST_INT_TIME;
            s_q.ff_gain <= `SGSS_RST_FF_GAIN;
            s_q.spd_limit <= `SGSS_RST_SPD_LIMIT;
            s_q.ctrl_mode <= SGSS_MODE_POS;
            s_q.integ <= 1'b1;
            s_q.feat <= '1;
            s_q.ff_out <= `SGSS_RST_FF_GAIN;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // outputs, all from flip-flops
    assign rdata = s_q.rdata;
    assign pos_gain_out = pos_ramp;
    assign spd_gain_out = spd_ramp;
    assign ff_gain_out = s_q.ff_out;
    assign integral_en = s_q.integ;
    assign second_active = s_q.second;
    assign speed_limit_active = s_q.limit;
    assign speed_limit_cmd = s_q.limit_cmd;
    assign feat_en = s_q.feat;
    assign regeneration_alarm = s_q.alarm;
    assign alarm_code = s_q.alarm ? `SGSS_ALARM_CODE : 8'h00;

endmodule : sgss_selector

// ---- rtl/sgss_cfg.svh ----
// offsets, fields, reset values and timing of the gain switch selector
`ifndef SGSS_CFG_SVH
`define SGSS_CFG_SVH

// ==========================================================================
// register offsets (word index)
`define SGSS_OFF_MODE_SEL 8'h00
`define SGSS_OFF_THRESH 8'h01
`define SGSS_OFF_RAMP_TIME 8'h02
`define SGSS_OFF_POS_GAIN 8'h03
`define SGSS_OFF_SPD_GAIN 8'h04
`define SGSS_OFF_POS_COEF 8'h05
`define SGSS_OFF_SPD_COEF 8'h06
`define SGSS_OFF_INT_TIME 8'h07
`define SGSS_OFF_FF_GAIN 8'h08
`define SGSS_OFF_CTRL 8'h09
`define SGSS_OFF_SPD_LIMIT 8'h0A
`define SGSS_OFF_STATUS 8'h0B
`define SGSS_OFF_POS_OUT 8'h0C
`define SGSS_OFF_SPD_OUT 8'h0D

// ==========================================================================
// field positions
`define SGSS_SEL_LOW_LSB 0
`define SGSS_SEL_HIGH_LSB 4
`define SGSS_CTRL_GSEL_BIT 2
`define SGSS_ST_SECOND_BIT 0
`define SGSS_ST_LIMIT_BIT 1
`define SGSS_ST_ALARM_BIT 2
`define SGSS_ST_INTEG_BIT 3
`define SGSS_ST_RAMP_BIT 4
`define SGSS_COEF_FRAC 8

// ==========================================================================
// reset values (gains and integral time in tenths)
`define SGSS_RST_MODE_SEL 16'h0000
`define SGSS_RST_THRESH 16'h0000
`define SGSS_RST_RAMP_TIME 16'h0000
`define SGSS_RST_POS_GAIN 16'h0140
`define SGSS_RST_SPD_GAIN 16'h00B4
`define SGSS_RST_POS_COEF 16'h0100
`define SGSS_RST_SPD_COEF 16'h0100
`define SGSS_RST_INT_TIME 16'h0136
`define SGSS_RST_FF_GAIN 16'h012C
`define SGSS_RST_SPD_LIMIT 16'h0000

// ==========================================================================
// mode codes, lags, special values
`define SGSS_LOW_FIXED 4'h0
`define SGSS_LOW_TERMINAL 4'h1
`define SGSS_LOW_POS_DEV 4'h2
`define SGSS_LOW_SPD_CMD 4'h3
`define SGSS_LOW_MOTOR_SPD 4'h4
`define SGSS_HIGH_INTEG 4'h1
`define SGSS_LAG_POS 17'h00064
`define SGSS_LAG_SPEED 17'h0000A
`define SGSS_INT_OFF 16'h7530
`define SGSS_ALARM_CODE 8'h11

// ==========================================================================
// timing: one ramp step per tick
`define SGSS_CLK_NS 20
`define SGSS_TICK_NS 1000
`define SGSS_TICK_CYC ((`SGSS_TICK_NS + `SGSS_CLK_NS - 1) / `SGSS_CLK_NS)

`endif

// ---- rtl/sgss_pkg.sv ----
// types shared by the gain switch selector files
package sgss_pkg;

    // ======================================================================
    // control mode of the drive
    typedef enum logic [1:0] {
        SGSS_MODE_POS,
        SGSS_MODE_SPD,
        SGSS_MODE_TRQ
    } sgss_ctrl_e;

    // ======================================================================
    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } sgss_bus_s;

    // internal loop quantities, signed
    typedef struct packed {
        logic signed [15:0] pos_dev;
        logic signed [15:0] speed_cmd;
        logic signed [15:0] motor_speed;
        logic signed [15:0] torque_cmd;
    } sgss_loop_s;

    // enables of loop features
    typedef struct packed {
        logic gain_switch;
        logic notch;
        logic adaptive;
        logic torque_ff;
        logic friction;
        logic accel_fb;
        logic dist_obs;
        logic speed_obs;
        logic inertia_id;
    } sgss_feat_s;

    // ramp state
    typedef struct packed {
        logic [15:0] start;
        logic [15:0] target;
        logic [15:0] step;
        logic [15:0] value;
        logic [7:0] tick;
    } sgss_ramp_s;

    // selector state
    typedef struct packed {
        logic [15:0] mode_sel;
        logic [15:0] thresh;
        logic [15:0] ramp_time;
        logic [15:0] pos_gain;
        logic [15:0] spd_gain;
        logic [15:0] pos_coef;
        logic [15:0] spd_coef;
        logic [15:0] int_time;
        logic [15:0] ff_gain;
        sgss_ctrl_e ctrl_mode;
        logic gsel_assigned;
        logic [15:0] spd_limit;
        logic second;
        logic alarm;
        logic limit;
        logic integ;
        logic signed [15:0] limit_cmd;
        sgss_feat_s feat;
        logic [15:0] ff_out;
        logic [15:0] rdata;
    } sgss_state_s;

endpackage : sgss_pkg

// ---- rtl/sgss_gain_ramp.sv ----
// linear ramp of one gain toward its target
`timescale 1ns/10ps
`include "sgss_cfg.svh"

module sgss_gain_ramp #(
    parameter int TICK_CYC = `SGSS_TICK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [15:0] target,
    input wire logic [15:0] ramp_len,
    output logic [15:0] value,
    output logic busy
);
    import sgss_pkg::*;

    sgss_ramp_s r_q;
    sgss_ramp_s r_d;
    logic signed [16:0] delta;
    logic signed [33:0] prod;
    logic signed [33:0] frac;
    logic [15:0] nstep;

    // ======================================================================
    // next state
    always_comb begin
        r_d = r_q;
        nstep = r_q.step + 16'h0001;
        delta = $signed({1'b0, r_q.target}) - $signed({1'b0, r_q.start});
        prod = 34'(delta) * $signed({18'h00000, nstep});
        // division kept: ramp lengths are arbitrary, not powers of two
        frac = (ramp_len == 16'h0000) ? 34'sh0 : prod / $signed({18'h00000, ramp_len});
        if (target != r_q.target) begin
            // restart from the present value
            r_d.start = r_q.value;
            r_d.target = target;
            r_d.step = 16'h0000;
            r_d.tick = 8'h00;
            if (ramp_len == 16'h0000) begin
                r_d.value = target;
            end
        end else if (r_q.value != r_q.target) begin
            if (ramp_len == 16'h0000 || r_q.step >= ramp_len) begin
                r_d.value = r_q.target;
            end else if (r_q.tick == 8'(TICK_CYC - 1)) begin
                r_d.tick = 8'h00;
                r_d.step = nstep;
                r_d.value = 16'($signed({1'b0, r_q.start}) + 17'(frac));
            end else begin
                r_d.tick = r_q.tick + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '0;
        end else if (ce) begin
            r_q <= r_d;
        end
    end

    assign value = r_q.value;
    assign busy = (r_q.value != r_q.target);

endmodule : sgss_gain_ramp

// ---- bench/sgss_selector_props.sv ----
// assertions on the ports of the gain switch selector
`timescale 1ns/10ps
`include "sgss_cfg.svh"
module sgss_selector_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire sgss_pkg::sgss_bus_s bus,
    input wire sgss_pkg::sgss_loop_s loop_in,
    input wire logic second_active,
    input wire logic speed_limit_active,
    input wire logic signed [15:0] speed_limit_cmd,
    input wire sgss_pkg::sgss_feat_s feat_en,
    input wire logic regeneration_alarm,
    input wire logic [7:0] alarm_code
);
    import sgss_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ====
    // helpers: sign relations, alarm clear
    logic signed [15:0] tq;
    logic signed [15:0] ms;
    logic opp;
    logic same;
    logic clr;
    assign tq = loop_in.torque_cmd;
    assign ms = loop_in.motor_speed;
    assign opp = (tq != 0) && (ms != 0) && (tq[15] != ms[15]);
    assign same = (tq != 0) && (ms != 0) && !opp;
    assign clr = ce && bus.wr && bus.addr == `SGSS_OFF_STATUS && bus.wdata[`SGSS_ST_ALARM_BIT];
    // ====
    // assertions
    alarm_code_a: assert property (alarm_code == (regeneration_alarm ? `SGSS_ALARM_CODE : 8'h00))
        else $error("alarm code does not follow alarm");
    alarm_cause_a: assert property ($rose(regeneration_alarm) |-> $past(opp))
        else $error("alarm rose without reverse drive");
    // feat_en lags the mode one edge; skip right after a write
    alarm_set_a: assert property (ce && $past(ce) && !$past(bus.wr) && feat_en == '0 && opp |=> regeneration_alarm)
        else $error("reverse drive without alarm");
    alarm_sticky_a: assert property (regeneration_alarm && !clr |=> regeneration_alarm)
        else $error("alarm dropped without clear");
    limit_dir_a: assert property ($rose(speed_limit_active) |-> $past(same))
        else $error("limit against torque direction");
    limit_mode_a: assert property (speed_limit_active |-> feat_en == '0)
        else $error("limit outside torque mode");
    limit_sign_a: assert property (speed_limit_active && speed_limit_cmd != 0 |-> speed_limit_cmd[15] == $past(tq[15]))
        else $error("limit command sign wrong");
    torque_first_a: assert property (feat_en == '0 |-> !second_active)
        else $error("second set in torque mode");
    frozen_state_a: assert property (!ce |=> $stable(second_active) && $stable(regeneration_alarm))
        else $error("state moved with enable low");
    second_cov: cover property ($rose(second_active));
    limit_cov: cover property ($rose(speed_limit_active));
    alarm_cov: cover property ($rose(regeneration_alarm));
endmodule : sgss_selector_props

bind sgss_selector sgss_selector_props u_props (
    .clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus), .loop_in(loop_in), .second_active(second_active),
    .speed_limit_active(speed_limit_active), .speed_limit_cmd(speed_limit_cmd), .feat_en(feat_en),
    .regeneration_alarm(regeneration_alarm), .alarm_code(alarm_code));

// ---- bench/sgss_far_model.sv ----
// far side model: gain select terminal, loop quantities and host tuning values
`timescale 1ns/10ps
module sgss_far_model (
    input wire logic clk,
    output logic gain_sel,
    output sgss_pkg::sgss_loop_s loop_in
);
    import sgss_pkg::*;
    // ====
    // host starting values, in tenths
    localparam logic [15:0] SPD_STD = 16'h00B4;
    localparam logic [15:0] POS_STD = 16'h0140;
    localparam logic [15:0] INT_STD = 16'h0136;
    localparam logic [15:0] FF_STD = 16'h012C;
    initial begin
        gain_sel = 1'b0;
        loop_in = '0;
    end
    // changes land just after an edge
    task set_term(input logic v);
        @(posedge clk);
        gain_sel <= v;
    endtask : set_term
    task set_loop(input logic [15:0] dev, cmd, spd, trq);
        @(posedge clk);
        loop_in <= '{dev, cmd, spd, trq};
    endtask : set_loop
endmodule : sgss_far_model

// ---- bench/sgss_selector_tb.sv ----
// self-checking bench of the gain switch selector
`timescale 1ns/10ps
`include "sgss_cfg.svh"
module sgss_selector_tb;
    import sgss_pkg::*;
    logic clk = 1'b0;
    logic rst_n;
    logic ce;
    sgss_bus_s bus;
    logic [15:0] rdata;
    logic gain_sel;
    sgss_loop_s loop_in;
    logic [15:0] pos_gain_out;
    logic [15:0] spd_gain_out;
    logic [15:0] ff_gain_out;
    logic integral_en;
    logic second_active;
    logic speed_limit_active;
    logic signed [15:0] speed_limit_cmd;
    sgss_feat_s feat_en;
    logic regeneration_alarm;
    logic [7:0] alarm_code;
    int miscompares = 0;
    int check_count = 0;
    int lag;
    always #10 clk = ~clk;
    sgss_far_model far (.clk(clk), .gain_sel(gain_sel), .loop_in(loop_in));
    // short ticks shorten the ramps
    sgss_selector #(.TICK_CYC(2)) uut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus), .rdata(rdata), .gain_sel(gain_sel), .loop_in(loop_in),
        .pos_gain_out(pos_gain_out), .spd_gain_out(spd_gain_out), .ff_gain_out(ff_gain_out),
        .integral_en(integral_en), .second_active(second_active), .speed_limit_active(speed_limit_active),
        .speed_limit_cmd(speed_limit_cmd), .feat_en(feat_en), .regeneration_alarm(regeneration_alarm),
        .alarm_code(alarm_code));
    // ====
    // tasks
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        check("rdata", rdata, exp);
    endtask : rd
    task sel(input int m, v, input logic x);
        far.set_loop(m == 2 ? 16'(v) : '0, m == 3 ? 16'(v) : '0, m == 4 ? 16'(v) : '0, '0);
        tick(3);
        check("second", 16'(second_active), 16'(x));
    endtask : sel
    task trq(input int spd, t, input logic x);
        far.set_loop(16'h0384, '0, 16'(spd), 16'(t));
        tick(3);
        check("limit", 16'(speed_limit_active), 16'(x));
    endtask : trq
    task give_verdict;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    // ====
    // watchdog, well past the test length
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
    // ====
    // tests
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        bus = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        tick(3);
        check("pos_gain", pos_gain_out, far.POS_STD);
        check("ff_gain", ff_gain_out, far.FF_STD);
        check("feat", 16'(feat_en), 16'h01FF);
        rd(`SGSS_OFF_INT_TIME, far.INT_STD);
        rd(`SGSS_OFF_SPD_GAIN, far.SPD_STD);
        rd(8'h3F, 16'h0000);
        wr(`SGSS_OFF_CTRL, 16'h0004);
        far.set_term(1'b1);
        sel(2, 900, 1'b0);
        wr(`SGSS_OFF_MODE_SEL, 16'h0001);
        sel(2, 0, 1'b1);
        far.set_term(1'b0);
        sel(2, 0, 1'b0);
        far.set_term(1'b1);
        wr(`SGSS_OFF_CTRL, 16'h0000);
        sel(2, 0, 1'b0);
        far.set_term(1'b0);
        wr(`SGSS_OFF_CTRL, 16'h0004);
        @(posedge clk);
        ce <= 1'b0;
        far.set_term(1'b1);
        sel(2, 0, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        sel(2, 0, 1'b1);
        far.set_term(1'b0);
        wr(`SGSS_OFF_THRESH, 16'h0010);
        wr(`SGSS_OFF_POS_COEF, 16'h0200);
        wr(`SGSS_OFF_SPD_COEF, 16'h0200);
        for (int m = 2; m <= 4; m++) begin
            lag = (m == 2) ? 100 : 10;
            wr(`SGSS_OFF_MODE_SEL, 16'(m));
            sel(m, 16 + lag, 1'b0);
            sel(m, -(17 + lag), 1'b1);
            sel(m, 16 + lag, 1'b1);
            sel(m, 15 + lag, 1'b0);
        end
        wr(`SGSS_OFF_RAMP_TIME, 16'h0004);
        wr(`SGSS_OFF_MODE_SEL, 16'h0002);
        sel(2, 300, 1'b1);
        rd(`SGSS_OFF_STATUS, 16'h0019);
        tick(12);
        check("pos_gain", pos_gain_out, 16'h0280);
        check("spd_gain", spd_gain_out, 16'h0168);
        sel(2, 0, 1'b0);
        tick(12);
        check("pos_gain", pos_gain_out, 16'h0140);
        wr(`SGSS_OFF_CTRL, 16'h0005);
        tick(12);
        check("ff_gain", ff_gain_out, 16'h0000);
        check("pos_gain", pos_gain_out, 16'h0000);
        wr(`SGSS_OFF_CTRL, 16'h0004);
        wr(`SGSS_OFF_MODE_SEL, 16'h0012);
        sel(2, 300, 1'b0);
        check("integral", 16'(integral_en), 16'h0000);
        wr(`SGSS_OFF_MODE_SEL, 16'h0010);
        tick(3);
        check("integral", 16'(integral_en), 16'h0001);
        wr(`SGSS_OFF_INT_TIME, 16'h7530);
        tick(3);
        check("integral", 16'(integral_en), 16'h0000);
        wr(`SGSS_OFF_MODE_SEL, 16'h0002);
        wr(`SGSS_OFF_SPD_LIMIT, 16'h0064);
        wr(`SGSS_OFF_CTRL, 16'h0006);
        trq(100, 50, 1'b1);
        check("feat", 16'(feat_en), 16'h0000);
        check("second", 16'(second_active), 16'h0000);
        check("limit_cmd", speed_limit_cmd, 16'h0064);
        trq(99, 50, 1'b0);
        trq(-100, -50, 1'b1);
        check("limit_cmd", speed_limit_cmd, 16'hFF9C);
        trq(-200, 50, 1'b0);
        check("alarm_code", alarm_code, 16'h0011);
        wr(`SGSS_OFF_STATUS, 16'h0004);
        tick(2);
        check("alarm", 16'(regeneration_alarm), 16'h0001);
        trq(0, 0, 1'b0);
        wr(`SGSS_OFF_STATUS, 16'h0004);
        tick(2);
        check("alarm", 16'(regeneration_alarm), 16'h0000);
        give_verdict();
    end
endmodule : sgss_selector_tb
